/* File: bench/dmem_model.sv */
// Byte-wide data memory partner with synchronous read
`timescale 1ns/1ps
`default_nettype none
module dmem_model (
   input wire logic clk_in,
   input wire move_or_ret_pkg::dmem_req_t req_in,
   output logic [7:0] rdata_out
);
   logic [7:0] mem [65536];
   initial begin
      for (int i = 0; i < 65536; i++) begin
         mem[i] = 8'(i * 7 + 3);
      end
      rdata_out = 8'h00;
   end
   // Idle bus flips each cycle so a stale byte never passes for data
   always @(posedge clk_in) begin
      rdata_out <= req_in.re ? mem[req_in.addr] : ~rdata_out;
      if (req_in.we) begin
         mem[req_in.addr] <= req_in.wdata;
      end
   end
endmodule
`default_nettype wire

/* File: bench/move_or_cond_return_exec_bench.sv */
// Self-checking bench for the move, OR and conditional return unit
`timescale 1ns/1ps
`default_nettype none
`include "move_or_ret_defines.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module move_or_cond_return_exec_bench;
   logic clk = 1'b0, rst = 1'b1, rdq = 1'b0, wrq = 1'b0, wt, global_int_enable;
   logic [4:0] adr = 5'h00;
   logic [31:0] wd = 32'h0, rv, rdo;
   logic [3:0] pins = 4'h0;
   logic [7:0] mrd;
   logic [15:0] pcb, p [4];
   move_or_ret_pkg::dmem_req_t req;
   int mismatches = 0, n_tests = 0;
   always #12.5 clk = ~clk;
   move_or_cond_return_exec dut_u (.ref_clk_in(clk), .rst_in(rst),
      .avs_address_in(adr), .avs_read_in(rdq), .avs_write_in(wrq),
      .avs_writedata_in(wd), .avs_byteenable_in(4'hf),
      .avs_readdata_out(rdo), .avs_waitrequest_out(wt),
      .dmem_rdata_in(mrd), .dmem_req_out(req),
      .rx_busy_flag_in(pins[0]), .rx_fault_flag_in(pins[1]),
      .rx_word_ready_flag_in(pins[2]), .tx_queue_full_flag_in(pins[3]),
      .global_int_enable_out(global_int_enable));
   dmem_model mem_u (.clk_in(clk), .req_in(req), .rdata_out(mrd));
   task automatic bus(input logic w, input logic [4:0] a,
      input logic [31:0] d);
      adr <= a;
      wd <= d;
      wrq <= w;
      rdq <= !w;
      do begin
         @(posedge clk);
      end while (wt !== 1'b0);
      rv = rdo;
      wrq <= 1'b0;
      rdq <= 1'b0;
      @(posedge clk);
   endtask
   // Leaves the settled control word in rv
   task automatic exec(input logic [31:0] ins);
      bus(1'b0, `OFS_PC, 32'h0);
      pcb = rv[15:0];
      bus(1'b1, `OFS_INSTR, ins);
      do begin
         bus(1'b0, `OFS_CTRL, 32'h0);
      end while (rv[`CTRL_BUSY_BIT] !== 1'b0);
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      print_verdict();
   end
   initial begin
      move_or_ret_pkg::instr_t i;
      logic [7:0] v, a, e, fl, u;
      logic [3:0] fc, fe;
      logic [22:0] st;
      logic [6:0] ce;
      logic [15:0] ad;
      logic [4:0] dst;
      logic [3:0] ops [8];
      logic [3:0] rops [4];
      logic tk, ge;
      ops = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'h7, 4'h8, 4'hb};
      rops = '{4'h3, 4'h5, 4'h9, 4'ha};
      void'($urandom(82));
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      bus(1'b0, `OFS_CTRL, 32'h0);
      `CHK(rv, 32'h0)
      $display("test reset done");
      for (int k = 0; k < 8; k++) begin
         v = 8'($urandom);
         a = 8'($urandom);
         u = 8'($urandom);
         fc = 4'($urandom);
         i = 32'($urandom);
         i.op = rops[k % 4];
         i.rs = 5'h05;
         // Limited forms drop the top bit of a full random field
         dst = (i.op inside {4'h3, 4'h9}) ? {1'b0, i.rd[3:0]} : i.rd;
         bus(1'b1, `OFS_CTRL, {28'h0, fc});
         bus(1'b1, `OFS_REGWIN, {24'h0, a});
         bus(1'b1, `OFS_REGWIN, {24'h5, v});
         bus(1'b1, `OFS_REGWIN, {19'h0, dst, u});
         if (dst == 5'h00) a = u;
         if (dst == 5'h05) v = u;
         case (i.op)
            4'h3: e = i.imm;
            4'h5: e = v;
            4'h9: e = u | i.imm;
            default: e = v | a;
         endcase
         fe = (i.op inside {4'h9, 4'ha}) ? {e[7], e == 8'h00, fc[1:0]} :
            fc;
         exec(i);
         `CHK(rv[3:0], fe)
         bus(1'b0, `OFS_REGWIN, 32'h0);
         `CHK(rv[12:0], {dst, e})
      end
      $display("test register ops done");
      for (int k = 0; k < 24; k++) begin
         for (int j = 0; j < 4; j++) p[j] = 16'($urandom);
         a = 8'($urandom);
         v = 8'($urandom);
         fc = 4'($urandom);
         i = 32'($urandom);
         i.op = ops[k % 8];
         i.rs = 5'h05;
         i.rd = 5'h05;
         bus(1'b1, `OFS_CTRL, {28'h0, fc});
         bus(1'b1, `OFS_PTR_LO, {p[1], p[0]});
         bus(1'b1, `OFS_PTR_HI, {p[3], p[2]});
         bus(1'b1, `OFS_REGWIN, {24'h0, a});
         bus(1'b1, `OFS_REGWIN, {24'h5, v});
         case (i.op)
            4'h1, 4'h7: ad = p[i.ir] + 16'(a);
            4'h2, 4'h8: ad = p[3] + 16'(i.imm);
            4'h4: ad = p[i.ir];
            default: ad = p[i.ir] + 16'(i.mode == `MODE_PREINC);
         endcase
         if (i.op inside {4'h0, 4'h6, 4'hb})
            p[i.ir] = (i.mode == `MODE_POSTDEC) ? p[i.ir] - 16'h1 :
               p[i.ir] + 16'(i.mode != `MODE_KEEP);
         e = (i.op < 4'h3) ? mem_u.mem[ad] : (i.op == 4'h4) ? i.imm :
            (i.op == 4'hb) ? (v | a) : v;
         fe = (i.op == 4'hb) ? {e[7], e == 8'h00, fc[1:0]} : fc;
         exec(i);
         `CHK(rv[3:0], fe)
         `CHK(mem_u.mem[ad], e)
         bus(1'b0, `OFS_REGWIN, 32'h0);
         `CHK(rv[12:0], {5'h05, (i.op < 4'h3) ? e : v})
         bus(1'b0, `OFS_PTR_LO, 32'h0);
         `CHK(rv, {p[1], p[0]})
         bus(1'b0, `OFS_PTR_HI, 32'h0);
         `CHK(rv, {p[3], p[2]})
      end
      $display("test memory moves done");
      for (int k = 0; k < 40; k++) begin
         fc = 4'($urandom);
         st = 23'($urandom);
         pins <= 4'($urandom);
         i = 32'($urandom);
         i.op = k[0] ? `OP_RCC : `OP_COND_RETURN_OP;
         i.rd = 5'($urandom % 20);
         bus(1'b1, `OFS_STACK, {9'h0, st});
         bus(1'b1, `OFS_CTRL, {27'h0, k[1], fc});
         fl = {pins, fc[3], fc[0], fc[1], fc[2]};
         tk = k[0] ? (i.rd < 5'd18 && fl[(i.rd < 5'd4) ? 0 : i.rd / 2 - 1]
            == !i.rd[0]) : (fl[i.f] == i.s);
         ge = !tk ? k[1] : (i.g == `GSEL_KEEP) ? k[1] :
            (i.g == `GSEL_RESTORE) ? st[6] : (i.g == `GSEL_SET);
         // Stack word: pc [22:7], enable [6], flags NZCV [5:2], bank [1:0]
         ce = (tk && i.rs[0]) ? {st[1:0], ge, st[5:2]} : {2'h0, ge, fc};
         exec(i);
         `CHK(rv[6:0], ce)
         `CHK(global_int_enable, ge)
         bus(1'b0, `OFS_PC, 32'h0);
         `CHK(rv[15:0], tk ? st[22:7] : pcb + 16'h1)
      end
      $display("test conditional returns done");
      print_verdict();
   end
endmodule
`default_nettype wire

/* File: pkg/move_or_ret_defines.svh */
// Offsets, field positions, opcodes and reset values of the execution unit
`ifndef MOVE_OR_RET_DEFINES_SVH
`define MOVE_OR_RET_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define OFS_INSTR 5'h00
`define OFS_CTRL 5'h04
`define OFS_PC 5'h08
`define OFS_PTR_LO 5'h0c
`define OFS_PTR_HI 5'h10
`define OFS_REGWIN 5'h14
`define OFS_STACK 5'h18

// ----------------------------------------------------------------
// Control register and register window field positions
// ----------------------------------------------------------------
`define CTRL_FLAGS_LSB 0
`define CTRL_GIE_BIT 4
`define CTRL_BANK_LSB 5
`define CTRL_BUSY_BIT 8
`define CTRL_PINS_LSB 12
`define CTRL_SP_LSB 16
`define WIN_IDX_LSB 8

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define OP_LD_IDX 4'h0
`define OP_LD_RREL 4'h1
`define OP_LD_IMMREL 4'h2
`define OP_MVI_REG 4'h3
`define OP_MVI_MEM 4'h4
`define OP_MOV_RR 4'h5
`define OP_ST_IDX 4'h6
`define OP_ST_RREL 4'h7
`define OP_ST_IMMREL 4'h8
`define OP_ORI 4'h9
`define OP_ORA_R 4'ha
`define OP_ORA_M 4'hb
`define OP_COND_RETURN_OP 4'hc
`define OP_RCC 4'hd

// ----------------------------------------------------------------
// Index modes, interrupt-enable selects, condition codes
// ----------------------------------------------------------------
`define MODE_POSTDEC 2'h0
`define MODE_KEEP 2'h1
`define MODE_POSTINC 2'h2
`define MODE_PREINC 2'h3
`define GSEL_KEEP 2'h0
`define GSEL_RESTORE 2'h1
`define GSEL_SET 2'h2
`define GSEL_CLEAR 2'h3
`define CC_LAST 5'h11

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PC_RST 16'h0000
`define PTR_RST 16'h0000
`define FLAGS_RST 4'h0
`define BANK_RST 2'h0
`define GIE_RST 1'b0
`define REG_RST 8'h00

`endif

/* File: pkg/move_or_ret_pkg.sv */
// Types shared by the execution unit
package move_or_ret_pkg;

   typedef enum logic [3:0] {
      S_IDLE = 4'h1,
      S_T1 = 4'h2,
      S_T2 = 4'h4,
      S_T3 = 4'h8
   } exec_state_t;

   typedef struct packed {
      logic n;
      logic z;
      logic c;
      logic v;
   } alu_flags_t;

   // rs[0] carries the restore select in returns, and rd the condition code in RCC
   typedef struct packed {
      logic [3:0] op;
      logic [1:0] mode;
      logic [1:0] ir;
      logic [7:0] imm;
      logic [1:0] g;
      logic s;
      logic [4:0] rs;
      logic [2:0] f;
      logic [4:0] rd;
   } instr_t;

   typedef struct packed {
      logic [15:0] pc;
      logic global_int_enable;
      alu_flags_t flags;
      logic [1:0] bank;
   } stack_entry_t;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic re;
      logic we;
   } dmem_req_t;

endpackage

/* File: verilog/move_or_cond_return_exec.sv */
// Execution unit for data moves, OR operations and conditional returns
//
// The Avalon-MM register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "move_or_ret_defines.svh"
module move_or_cond_return_exec #(
   parameter int STACK_DEPTH = 16
) (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic [4:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   input wire logic [7:0] dmem_rdata_in,
   output move_or_ret_pkg::dmem_req_t dmem_req_out,
   input wire logic rx_busy_flag_in,
   input wire logic rx_fault_flag_in,
   input wire logic rx_word_ready_flag_in,
   input wire logic tx_queue_full_flag_in,
   output logic global_int_enable_out
);
   localparam int SPW = $clog2(STACK_DEPTH);

   move_or_ret_pkg::exec_state_t state_q;
   move_or_ret_pkg::instr_t ins;
   move_or_ret_pkg::alu_flags_t flags_q;
   move_or_ret_pkg::stack_entry_t stack_q [STACK_DEPTH];
   move_or_ret_pkg::stack_entry_t top;
   logic [31:0] ir_q;
   logic [7:0] regs_q [32];
   logic [7:0] alt_acc_q;
   logic [15:0] ptr_q [4];
   logic [1:0] bank_q;
   logic [15:0] pc_q;
   logic [SPW-1:0] sp_q;
   logic [4:0] win_q;
   logic [3:0] pins_s;
   logic [7:0] fv;
   logic busy, req, ack, bus_wr, commit;
   logic [31:0] rd_mux, wdm;
   logic [7:0] acc, rs_val, res;
   logic [15:0] ptr_sel, ptr_next, mem_addr;
   logic is_idx, is_load, is_store, is_mem, is_ret, nz_we;
   logic cond, cc_met, ret_taken;
   logic [2:0] cc_idx;
   logic reg_we;
   logic [4:0] reg_idx;
   logic [7:0] reg_val;

   // Index 0 is the accumulator; the bank selection swaps in the alternate
   function automatic logic [7:0] rd_reg(input logic [4:0] idx);
      rd_reg = (idx == 5'h00 && bank_q[0]) ? alt_acc_q : regs_q[idx];
   endfunction

   function automatic logic [4:0] lim(input logic [4:0] idx);
      lim = {1'b0, idx[3:0]};
   endfunction

   function automatic logic [31:0] be_merge(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] be);
      for (int i = 0; i < 4; i++) begin
         be_merge[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
      end
   endfunction

   pin_sync2 #(.W(4)) u_sync (
      .clk_in(ref_clk_in),
      .rst_in(rst_in),
      .d_in({tx_queue_full_flag_in, rx_word_ready_flag_in,
             rx_fault_flag_in, rx_busy_flag_in}),
      .q_out(pins_s)
   );

   // ----------------------------------------------------------------
   // Avalon slave
   // ----------------------------------------------------------------
   // Writes stall while an instruction runs, so bus and core never
   // update the same state in one cycle.
   assign busy = (state_q != move_or_ret_pkg::S_IDLE);
   assign req = avs_read_in | avs_write_in;
   assign ack = ~avs_waitrequest_out;
   assign bus_wr = ack & avs_write_in;
   assign top = stack_q[SPW'(sp_q - 1'b1)];

   always_comb begin
      rd_mux = 32'h0;
      case (avs_address_in)
         `OFS_INSTR: rd_mux = ir_q;
         `OFS_CTRL: begin
            rd_mux[`CTRL_FLAGS_LSB +: 4] = flags_q;
            rd_mux[`CTRL_GIE_BIT] = global_int_enable_out;
            rd_mux[`CTRL_BANK_LSB +: 2] = bank_q;
            rd_mux[`CTRL_BUSY_BIT] = busy;
            rd_mux[`CTRL_PINS_LSB +: 4] = pins_s;
            rd_mux[`CTRL_SP_LSB +: SPW] = sp_q;
         end
         `OFS_PC: rd_mux[15:0] = pc_q;
         `OFS_PTR_LO: rd_mux = {ptr_q[1], ptr_q[0]};
         `OFS_PTR_HI: rd_mux = {ptr_q[3], ptr_q[2]};
         `OFS_REGWIN: rd_mux[12:0] = {win_q, rd_reg(win_q)};
         `OFS_STACK: rd_mux[22:0] = top;
         default: rd_mux = 32'h0;
      endcase
      wdm = be_merge(rd_mux, avs_writedata_in, avs_byteenable_in);
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         avs_waitrequest_out <= 1'b1;
         avs_readdata_out <= 32'h0;
      end else begin
         avs_waitrequest_out <= ~(req & ~ack & ~(avs_write_in & busy));
         if (req & ~ack) begin
            avs_readdata_out <= rd_mux;
         end
      end
   end

   // ----------------------------------------------------------------
   // Decode and datapath
   // ----------------------------------------------------------------
   always_comb begin
      ins = move_or_ret_pkg::instr_t'(ir_q);
      acc = rd_reg(5'h00);
      ptr_sel = ptr_q[ins.ir];
      rs_val = rd_reg(ins.rs);
      fv = {pins_s, flags_q.n, flags_q.v, flags_q.c, flags_q.z};
      is_idx = ins.op == `OP_LD_IDX || ins.op == `OP_ST_IDX ||
               ins.op == `OP_ORA_M;
      is_load = ins.op == `OP_LD_IDX || ins.op == `OP_LD_RREL ||
                ins.op == `OP_LD_IMMREL;
      is_store = ins.op == `OP_ST_IDX || ins.op == `OP_ST_RREL ||
                 ins.op == `OP_ST_IMMREL || ins.op == `OP_MVI_MEM ||
                 ins.op == `OP_ORA_M;
      is_mem = is_load | is_store;
      is_ret = ins.op == `OP_COND_RETURN_OP || ins.op == `OP_RCC;
      case (ins.mode)
         `MODE_POSTDEC: ptr_next = ptr_sel - 16'h0001;
         `MODE_KEEP: ptr_next = ptr_sel;
         default: ptr_next = ptr_sel + 16'h0001;
      endcase
      case (ins.op)
         `OP_LD_RREL, `OP_ST_RREL: mem_addr = ptr_sel + {8'h00, acc};
         `OP_LD_IMMREL, `OP_ST_IMMREL:
            mem_addr = ptr_q[3] + {8'h00, ins.imm};
         `OP_MVI_MEM: mem_addr = ptr_sel;
         default: mem_addr = (ins.mode == `MODE_PREINC) ? ptr_next : ptr_sel;
      endcase
      // Condition codes come in set/clear pairs after four Z codes
      cc_idx = (ins.rd < 5'h04) ? 3'h0 : 3'(ins.rd[4:1] - 4'h1);
      cc_met = (ins.rd <= `CC_LAST) && (fv[cc_idx] == ~ins.rd[0]);
      cond = (ins.op == `OP_COND_RETURN_OP) ? (fv[ins.f] == ins.s) : cc_met;
      res = 8'h00;
      nz_we = 1'b0;
      reg_we = 1'b0;
      reg_idx = ins.rd;
      case (ins.op)
         `OP_LD_IDX, `OP_LD_RREL: begin
            res = dmem_rdata_in;
            reg_we = 1'b1;
         end
         `OP_LD_IMMREL: begin
            res = dmem_rdata_in;
            reg_idx = lim(ins.rd);
            reg_we = 1'b1;
         end
         `OP_MVI_REG: begin
            res = ins.imm;
            reg_idx = lim(ins.rd);
            reg_we = 1'b1;
         end
         `OP_MOV_RR: begin
            res = rs_val;
            reg_we = 1'b1;
         end
         `OP_ST_IDX, `OP_ST_RREL: res = rs_val;
         `OP_ST_IMMREL: res = rd_reg(lim(ins.rs));
         `OP_MVI_MEM: res = ins.imm;
         `OP_ORI: begin
            res = rd_reg(lim(ins.rd)) | ins.imm;
            reg_idx = lim(ins.rd);
            reg_we = 1'b1;
            nz_we = 1'b1;
         end
         `OP_ORA_R: begin
            res = rs_val | acc;
            reg_we = 1'b1;
            nz_we = 1'b1;
         end
         `OP_ORA_M: begin
            res = rs_val | acc;
            nz_we = 1'b1;
         end
         default: res = 8'h00;
      endcase
   end

   // Register ops finish in T2, memory ops in T3
   assign commit = (state_q == move_or_ret_pkg::S_T2 && !is_mem) ||
                   state_q == move_or_ret_pkg::S_T3;
   assign ret_taken = commit && is_ret && cond;

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_q <= move_or_ret_pkg::S_IDLE;
         ir_q <= 32'h0;
      end else begin
         case (state_q)
            move_or_ret_pkg::S_IDLE: begin
               if (bus_wr && avs_address_in == `OFS_INSTR) begin
                  ir_q <= wdm;
                  state_q <= move_or_ret_pkg::S_T1;
               end
            end
            move_or_ret_pkg::S_T1: state_q <= move_or_ret_pkg::S_T2;
            move_or_ret_pkg::S_T2: state_q <= is_mem ?
               move_or_ret_pkg::S_T3 : move_or_ret_pkg::S_IDLE;
            move_or_ret_pkg::S_T3: state_q <= move_or_ret_pkg::S_IDLE;
            default: state_q <= move_or_ret_pkg::S_IDLE;
         endcase
      end
   end

   // Data memory strobes stand for exactly T2; read data is taken in T3
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         dmem_req_out <= '0;
      end else if (state_q == move_or_ret_pkg::S_T1 && is_mem) begin
         dmem_req_out.addr <= mem_addr;
         dmem_req_out.wdata <= res;
         dmem_req_out.re <= is_load;
         dmem_req_out.we <= is_store;
      end else begin
         dmem_req_out.re <= 1'b0;
         dmem_req_out.we <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Register file and index pointers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         for (int i = 0; i < 32; i++) begin
            regs_q[i] <= `REG_RST;
         end
         alt_acc_q <= `REG_RST;
         win_q <= 5'h00;
      end else if (bus_wr && avs_address_in == `OFS_REGWIN) begin
         win_q <= wdm[`WIN_IDX_LSB +: 5];
         if (wdm[`WIN_IDX_LSB +: 5] == 5'h00 && bank_q[0]) begin
            alt_acc_q <= wdm[7:0];
         end else begin
            regs_q[wdm[`WIN_IDX_LSB +: 5]] <= wdm[7:0];
         end
      end else if (commit && reg_we) begin
         if (reg_idx == 5'h00 && bank_q[0]) begin
            alt_acc_q <= res;
         end else begin
            regs_q[reg_idx] <= res;
         end
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         for (int i = 0; i < 4; i++) begin
            ptr_q[i] <= `PTR_RST;
         end
      end else if (bus_wr && avs_address_in == `OFS_PTR_LO) begin
         ptr_q[0] <= wdm[15:0];
         ptr_q[1] <= wdm[31:16];
      end else if (bus_wr && avs_address_in == `OFS_PTR_HI) begin
         ptr_q[2] <= wdm[15:0];
         ptr_q[3] <= wdm[31:16];
      end else if (commit && is_idx) begin
         ptr_q[ins.ir] <= ptr_next;
      end
   end

   // ----------------------------------------------------------------
   // Program counter, address stack, flags and enables
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         pc_q <= `PC_RST;
      end else if (bus_wr && avs_address_in == `OFS_PC) begin
         pc_q <= wdm[15:0];
      end else if (ret_taken) begin
         pc_q <= top.pc;
      end else if (commit) begin
         pc_q <= pc_q + 16'h0001;
      end
   end

   // Software pushes entries so a return has something to pop; the
   // entries carry no reset, only the stack pointer does
   always_ff @(posedge ref_clk_in) begin
      if (bus_wr && avs_address_in == `OFS_STACK) begin
         stack_q[sp_q] <= wdm[22:0];
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         sp_q <= '0;
      end else if (bus_wr && avs_address_in == `OFS_STACK) begin
         sp_q <= sp_q + 1'b1;
      end else if (ret_taken) begin
         sp_q <= sp_q - 1'b1;
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         flags_q <= `FLAGS_RST;
         bank_q <= `BANK_RST;
         global_int_enable_out <= `GIE_RST;
      end else if (bus_wr && avs_address_in == `OFS_CTRL) begin
         flags_q <= wdm[`CTRL_FLAGS_LSB +: 4];
         global_int_enable_out <= wdm[`CTRL_GIE_BIT];
         bank_q <= wdm[`CTRL_BANK_LSB +: 2];
      end else if (ret_taken) begin
         case (ins.g)
            `GSEL_RESTORE: global_int_enable_out <= top.global_int_enable;
            `GSEL_SET: global_int_enable_out <= 1'b1;
            `GSEL_CLEAR: global_int_enable_out <= 1'b0;
            default: global_int_enable_out <= global_int_enable_out;
         endcase
         if (ins.rs[0]) begin
            flags_q <= top.flags;
            bank_q <= top.bank;
         end
      end else if (commit && nz_we) begin
         flags_q.n <= res[7];
         flags_q.z <= (res == 8'h00);
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);

   property p_load_flags;
      commit && is_load |=> flags_q == $past(flags_q);
   endproperty
   a_load_flags: assert property (p_load_flags)
      else $error("load changed flags");

   property p_rrel_addr;
      state_q == move_or_ret_pkg::S_T1 &&
      (ins.op == `OP_LD_RREL || ins.op == `OP_ST_RREL)
      |=> dmem_req_out.addr == $past(ptr_sel) + {8'h00, $past(acc)};
   endproperty
   a_rrel_addr: assert property (p_rrel_addr)
      else $error("register-relative address wrong");

   property p_immrel_addr;
      state_q == move_or_ret_pkg::S_T1 && ins.op == `OP_LD_IMMREL
      |=> dmem_req_out.addr == $past(ptr_q[3]) + {8'h00, $past(ins.imm)}
          ##1 !dmem_req_out.re;
   endproperty
   a_immrel_addr: assert property (p_immrel_addr)
      else $error("immediate-relative address wrong");

   property p_mvi_mem;
      state_q == move_or_ret_pkg::S_T1 && ins.op == `OP_MVI_MEM
      |=> dmem_req_out.we && dmem_req_out.wdata == $past(ins.imm);
   endproperty
   a_mvi_mem: assert property (p_mvi_mem)
      else $error("immediate store data wrong");

   property p_ori_time;
      state_q == move_or_ret_pkg::S_T1 && ins.op == `OP_ORI
      |=> state_q == move_or_ret_pkg::S_T2
          ##1 state_q == move_or_ret_pkg::S_IDLE;
   endproperty
   a_ori_time: assert property (p_ori_time)
      else $error("OR-immediate not two T-states");

   property p_ora_mem_time;
      state_q == move_or_ret_pkg::S_T1 && ins.op == `OP_ORA_M
      |=> state_q == move_or_ret_pkg::S_T2 ##1
          state_q == move_or_ret_pkg::S_T3 ##1
          state_q == move_or_ret_pkg::S_IDLE;
   endproperty
   a_ora_mem_time: assert property (p_ora_mem_time)
      else $error("accumulator OR to memory not three T-states");

   property p_ora_reg_time;
      state_q == move_or_ret_pkg::S_T1 && ins.op == `OP_ORA_R
      |=> state_q == move_or_ret_pkg::S_T2
          ##1 state_q == move_or_ret_pkg::S_IDLE;
   endproperty
   a_ora_reg_time: assert property (p_ora_reg_time)
      else $error("accumulator OR to register not two T-states");

   property p_ora_flags;
      commit && ins.op == `OP_ORA_R
      |=> flags_q.z == ($past(res) == 8'h00) &&
          flags_q.c == $past(flags_q.c) && flags_q.v == $past(flags_q.v);
   endproperty
   a_ora_flags: assert property (p_ora_flags)
      else $error("accumulator OR flags wrong");

   property p_postinc;
      commit && is_idx && ins.mode == `MODE_POSTINC
      |=> ptr_q[$past(ins.ir)] == $past(ptr_sel) + 16'h0001;
   endproperty
   a_postinc: assert property (p_postinc)
      else $error("post-increment wrong");

   property p_ret_taken;
      ret_taken |=> pc_q == $past(top.pc) &&
                    sp_q == SPW'($past(sp_q) - 1'b1);
   endproperty
   a_ret_taken: assert property (p_ret_taken)
      else $error("taken return did not pop");

   property p_gie_clear;
      ret_taken && ins.g == `GSEL_CLEAR |=> !global_int_enable_out;
   endproperty
   a_gie_clear: assert property (p_gie_clear)
      else $error("interrupt enable not cleared");

   property p_not_taken;
      commit && is_ret && !cond
      |=> pc_q == $past(pc_q) + 16'h0001 && sp_q == $past(sp_q) &&
          flags_q == $past(flags_q) && bank_q == $past(bank_q) &&
          global_int_enable_out == $past(global_int_enable_out);
   endproperty
   a_not_taken: assert property (p_not_taken)
      else $error("untaken return changed state");

   c_ret_taken: cover property (ret_taken && ins.rs[0]);
   c_ret_skip: cover property (commit && is_ret && !cond);
   c_ora_mem: cover property (commit && ins.op == `OP_ORA_M);
   c_load_rrel: cover property (commit && ins.op == `OP_LD_RREL);
endmodule
`default_nettype wire

/* File: verilog/pin_sync2.sv */
// Two-stage synchroniser for asynchronous status pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync2 #(
   parameter int W = 4
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] meta_q;

   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk_in or posedge rst_in) begin
         if (rst_in) begin
            meta_q[i] <= 1'b0;
            q_out[i] <= 1'b0;
         end else begin
            meta_q[i] <= d_in[i];
            q_out[i] <= meta_q[i];
         end
      end
   end
endmodule
`default_nettype wire
